//--- logic/osc_ctrl_pkg.sv
// Package: register map, field layout, codes and constants of the oscillator select block
package osc_ctrl_pkg;

  // Register byte offsets on the APB
  localparam logic [11:0] OFS_OSC_CONTROL = 12'h000;
  localparam logic [11:0] OFS_CLOCK_DIVIDER = 12'h004;
  localparam logic [11:0] OFS_FAST_RC_TUNE = 12'h008;

  // Control register fields
  localparam int CTL_CURRENT_LSB = 12;
  localparam int CTL_NEW_LSB = 8;
  localparam int CTL_SEL_LOCK_BIT = 7;
  localparam int CTL_PIN_LOCK_BIT = 6;
  localparam int CTL_PLL_LOCK_BIT = 5;
  localparam int CTL_FAIL_BIT = 3;
  localparam int CTL_SEC_EN_BIT = 1;
  localparam int CTL_SWITCH_BIT = 0;

  // Divider register fields
  localparam int DIV_RECOVER_BIT = 15;
  localparam int DIV_DOZE_LSB = 12;
  localparam int DIV_DOZE_EN_BIT = 11;
  localparam int DIV_POST_LSB = 8;
  localparam int DIV_FIXED_ONE_BIT = 6;

  // Unlock key bytes
  localparam logic [7:0] KEY_HI_FIRST = 8'h78;
  localparam logic [7:0] KEY_HI_SECOND = 8'h9A;
  localparam logic [7:0] KEY_LO_FIRST = 8'h46;
  localparam logic [7:0] KEY_LO_SECOND = 8'h57;

  // Reset values
  localparam logic [2:0] DOZE_RESET = 3'h3;
  localparam logic [2:0] POSTSCALE_RESET = 3'h1;
  localparam logic [2:0] SOURCE_ERASED = 3'h7;
  localparam logic [1:0] PRIMARY_ERASED = 2'h3;
  localparam logic [1:0] SWITCH_MON_ERASED = 2'h3;

  // New-source cycles waited before the changeover
  localparam logic [3:0] SETTLE_CYCLES = 4'hA;

  // Postscaler code whose divide is 256 rather than 128
  localparam logic [2:0] POSTSCALE_MAX_CODE = 3'h7;
  localparam logic [3:0] POSTSCALE_MAX_SHIFT = 4'h8;

  typedef enum logic [2:0] {
    SRC_FAST_RC = 3'h0,
    SRC_FAST_RC_WITH_PLL = 3'h1,
    SRC_PRIMARY = 3'h2,
    SRC_PRIMARY_WITH_PLL = 3'h3,
    SRC_SECONDARY = 3'h4,
    SRC_LOW_POWER_RC = 3'h5,
    SRC_RESERVED = 3'h6,
    SRC_DIVIDED_FAST_RC = 3'h7
  } source_t;

  typedef enum logic [1:0] {
    PRI_EXTERNAL_CLOCK = 2'h0,
    PRI_CRYSTAL = 2'h1,
    PRI_HIGH_SPEED_CRYSTAL = 2'h2,
    PRI_INTERNAL_ONLY = 2'h3
  } primary_mode_t;

  // Gray coded along idle, ready, pll, settle, done
  typedef enum logic [2:0] {
    SW_IDLE = 3'h0,
    SW_WAIT_READY = 3'h1,
    SW_WAIT_PLL = 3'h3,
    SW_SETTLE = 3'h2,
    SW_DONE = 3'h6
  } switch_state_t;

  typedef enum logic [1:0] {
    KEY_NONE = 2'h0,
    KEY_FIRST = 2'h1,
    KEY_ARMED = 2'h2
  } key_state_t;

endpackage : osc_ctrl_pkg

//--- logic/osc_select_ctrl.sv
// Module: oscillator source selection, switch sequencing, doze and fast RC divider control
`timescale 1ns/10ps
module osc_select_ctrl
  import osc_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Nonvolatile configuration straps
  input wire logic [1:0] switchMonitorCfg,
  input wire logic [1:0] primaryModeCfg,
  input wire logic [2:0] initialSourceCfg,
  input wire logic pinMapLockOneWayCfg,
  // Indications from the analogue side and the monitor
  input wire logic clockFailDetect,
  input wire logic pllLocked,
  input wire logic newSourceReady,
  input wire logic newSourceTick,
  input wire logic interruptEvent,
  // Control outputs
  output logic [2:0] currentSource,
  output logic [2:0] requestedSource,
  output logic [1:0] primaryMode,
  output logic switchingEnabled,
  output logic failsafeMonitorEnable,
  output logic secondaryOscEnable,
  output logic pinMapLock,
  output logic switchInProgress,
  output logic [2:0] dozeRatioEffective,
  output logic [3:0] fastRcPostscaleShift,
  output logic [5:0] fastRcTrim
);

  typedef struct packed {
    logic strapsLoaded;
    logic [1:0] switchMonCfg;
    logic [1:0] primaryMode;
    logic [2:0] initialSource;
    logic oneWay;
    logic [2:0] currentSource;
    logic [2:0] newSource;
    logic switchRequest;
    logic selectionLock;
    logic pinMapLock;
    logic pllLockFlag;
    logic clockFail;
    logic secondaryEnable;
    logic recoverOnInterrupt;
    logic [2:0] dozeRatio;
    logic dozeEnable;
    logic [2:0] postscale;
    logic [5:0] trim;
    switch_state_t swState;
    logic [3:0] settleCount;
    key_state_t keyHi;
    key_state_t keyLo;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] dozeRatioEff;
    logic [3:0] postShift;
    logic switchEnOut;
    logic monitorEnOut;
    logic busyOut;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  function automatic logic usesPll(input logic [2:0] code);
    usesPll = (code == SRC_FAST_RC_WITH_PLL) || (code == SRC_PRIMARY_WITH_PLL);
  endfunction : usesPll

  // Key tracker: a pair of back-to-back key writes arms the next write of that byte
  function automatic key_state_t nextKey(input key_state_t cur, input logic laneOnly,
                                         input logic [7:0] data, input logic [7:0] first,
                                         input logic [7:0] second);
    if (laneOnly && data == first) begin
      nextKey = KEY_FIRST;
    end else if (laneOnly && cur == KEY_FIRST && data == second) begin
      nextKey = KEY_ARMED;
    end else begin
      nextKey = KEY_NONE;
    end
  endfunction : nextKey

  logic swEnable;
  logic lockActive;
  logic accessDone;
  logic wrCtl;
  logic wrDiv;
  logic wrTune;
  logic hiOpen;
  logic loOpen;
  logic [15:0] ctlRead;
  logic [15:0] divRead;

  always_comb begin
    state_nxt = state_r;
    swEnable = ~state_r.switchMonCfg[1];
    // The selection lock only bites while switching is enabled
    lockActive = swEnable && state_r.selectionLock;
    accessDone = psel && penable && state_r.pready;
    wrCtl = accessDone && pwrite && paddr == OFS_OSC_CONTROL;
    wrDiv = accessDone && pwrite && paddr == OFS_CLOCK_DIVIDER;
    wrTune = accessDone && pwrite && paddr == OFS_FAST_RC_TUNE;
    hiOpen = wrCtl && pstrb[1] && state_r.keyHi == KEY_ARMED;
    loOpen = wrCtl && pstrb[0] && state_r.keyLo == KEY_ARMED;

    ctlRead = 16'h0000;
    ctlRead[CTL_CURRENT_LSB +: 3] = state_r.currentSource;
    ctlRead[CTL_NEW_LSB +: 3] = state_r.newSource;
    ctlRead[CTL_SEL_LOCK_BIT] = state_r.selectionLock;
    ctlRead[CTL_PIN_LOCK_BIT] = state_r.pinMapLock;
    ctlRead[CTL_PLL_LOCK_BIT] = state_r.pllLockFlag;
    ctlRead[CTL_FAIL_BIT] = state_r.clockFail;
    ctlRead[CTL_SEC_EN_BIT] = state_r.secondaryEnable;
    ctlRead[CTL_SWITCH_BIT] = state_r.switchRequest && swEnable;
    divRead = 16'h0000;
    divRead[DIV_RECOVER_BIT] = state_r.recoverOnInterrupt;
    divRead[DIV_DOZE_LSB +: 3] = state_r.dozeRatio;
    divRead[DIV_DOZE_EN_BIT] = state_r.dozeEnable;
    divRead[DIV_POST_LSB +: 3] = state_r.postscale;
    divRead[DIV_FIXED_ONE_BIT] = 1'b1;

    // APB: one wait cycle, then the access completes
    // Read data is latched a cycle early so that it stands with pready
    state_nxt.pready = psel && penable && !state_r.pready;
    state_nxt.pslverr = 1'b0;
    if (psel && penable && !state_r.pready) begin
      state_nxt.prdata = 32'h0000_0000;
      case (paddr)
        OFS_OSC_CONTROL: state_nxt.prdata = {16'h0000, ctlRead};
        OFS_CLOCK_DIVIDER: state_nxt.prdata = {16'h0000, divRead};
        OFS_FAST_RC_TUNE: state_nxt.prdata = {26'h0, state_r.trim};
        default: state_nxt.pslverr = 1'b1;
      endcase
    end

    // A completed transfer ends an unfinished or armed key sequence unless it writes the next key byte on that lane
    if (accessDone) begin
      if (wrCtl) begin
        state_nxt.keyHi = nextKey(state_r.keyHi, pstrb == 4'h2, pwdata[15:8],
                                  KEY_HI_FIRST, KEY_HI_SECOND);
        state_nxt.keyLo = nextKey(state_r.keyLo, pstrb == 4'h1, pwdata[7:0],
                                  KEY_LO_FIRST, KEY_LO_SECOND);
      end else begin
        state_nxt.keyHi = KEY_NONE;
        state_nxt.keyLo = KEY_NONE;
      end
    end

    // Each byte lane has its own key pair; arming covers one transfer only
    // High byte: new source selection, frozen by the lock or with switching off
    if (hiOpen && swEnable && !lockActive) begin
      state_nxt.newSource = pwdata[CTL_NEW_LSB +: 3];
    end

    // Low byte
    if (loOpen) begin
      if (pwdata[CTL_SEL_LOCK_BIT]) begin
        state_nxt.selectionLock = 1'b1;
      end
      if (!(pinMapLockOneWayCfg && state_r.oneWay && state_r.pinMapLock)) begin
        state_nxt.pinMapLock = pwdata[CTL_PIN_LOCK_BIT];
      end
      if (!pwdata[CTL_FAIL_BIT]) begin
        state_nxt.clockFail = 1'b0;
      end
      state_nxt.secondaryEnable = pwdata[CTL_SEC_EN_BIT];
      // Writing zero to the switch request leaves it alone
      if (pwdata[CTL_SWITCH_BIT] && swEnable && !lockActive) begin
        state_nxt.switchRequest = 1'b1;
      end
    end

    if (wrDiv && pstrb[1]) begin
      state_nxt.recoverOnInterrupt = pwdata[DIV_RECOVER_BIT];
      state_nxt.dozeRatio = pwdata[DIV_DOZE_LSB +: 3];
      state_nxt.dozeEnable = pwdata[DIV_DOZE_EN_BIT];
      state_nxt.postscale = pwdata[DIV_POST_LSB +: 3];
    end
    // Interrupt wins over a simultaneous software set of doze enable
    if (state_r.recoverOnInterrupt && interruptEvent) begin
      state_nxt.dozeEnable = 1'b0;
    end
    if (wrTune && pstrb[0]) begin
      state_nxt.trim = pwdata[5:0];
    end

    // Switch sequencer
    case (state_r.swState)
      SW_IDLE: begin
        if (state_r.switchRequest && swEnable) begin
          if (state_r.newSource == state_r.currentSource) begin
            state_nxt.switchRequest = 1'b0;
          end else begin
            state_nxt.pllLockFlag = 1'b0;
            state_nxt.clockFail = 1'b0;
            state_nxt.swState = SW_WAIT_READY;
          end
        end
      end
      SW_WAIT_READY: begin
        // Start-up timing of the oscillator is judged outside this block
        if (newSourceReady) begin
          state_nxt.swState = usesPll(state_r.newSource) ? SW_WAIT_PLL : SW_SETTLE;
          state_nxt.settleCount = 4'h0;
        end
      end
      SW_WAIT_PLL: begin
        if (pllLocked) begin
          state_nxt.swState = SW_SETTLE;
          state_nxt.settleCount = 4'h0;
        end
      end
      SW_SETTLE: begin
        // Ticks seen before this state are not counted
        if (newSourceTick) begin
          state_nxt.settleCount = state_r.settleCount + 4'h1;
          if (state_r.settleCount == SETTLE_CYCLES - 4'h1) begin
            state_nxt.swState = SW_DONE;
          end
        end
      end
      SW_DONE: begin
        // Request clears in the same cycle as the changeover, so software can poll it
        state_nxt.currentSource = state_r.newSource;
        state_nxt.switchRequest = 1'b0;
        state_nxt.swState = SW_IDLE;
      end
      default: state_nxt.swState = SW_IDLE;
    endcase

    // PLL lock status tracks the current source outside a switch
    if (state_r.swState == SW_IDLE && !(state_r.switchRequest && swEnable)) begin
      state_nxt.pllLockFlag = pllLocked && usesPll(state_r.currentSource);
    end

    // Failure set wins over any clear in the same cycle
    if (clockFailDetect && !state_r.switchMonCfg[0] && swEnable) begin
      state_nxt.clockFail = 1'b1;
    end

    // With switching off the current source always follows the strap
    if (!swEnable) begin
      state_nxt.currentSource = state_r.initialSource;
      state_nxt.switchRequest = 1'b0;
      state_nxt.swState = SW_IDLE;
    end

    // Straps are caught on the first edge after reset release
    // Later strap changes are ignored until the next reset, except that clearing pinMapLockOneWayCfg undoes the one-way pin lock
    if (!state_r.strapsLoaded) begin
      state_nxt.strapsLoaded = 1'b1;
      state_nxt.switchMonCfg = switchMonitorCfg;
      state_nxt.primaryMode = primaryModeCfg;
      state_nxt.initialSource = initialSourceCfg;
      state_nxt.oneWay = pinMapLockOneWayCfg;
      state_nxt.currentSource = initialSourceCfg;
      state_nxt.newSource = initialSourceCfg;
    end

    state_nxt.dozeRatioEff = state_nxt.dozeEnable ? state_nxt.dozeRatio : 3'h0;
    state_nxt.postShift = (state_nxt.postscale == POSTSCALE_MAX_CODE) ? POSTSCALE_MAX_SHIFT
                          : {1'b0, state_nxt.postscale};
    // Registered copies, so that every output leaves a flip-flop
    state_nxt.switchEnOut = ~state_nxt.switchMonCfg[1];
    state_nxt.monitorEnOut = ~state_nxt.switchMonCfg[1] & ~state_nxt.switchMonCfg[0];
    state_nxt.busyOut = state_nxt.swState != SW_IDLE;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '0;
      state_r.switchMonCfg <= SWITCH_MON_ERASED;
      state_r.primaryMode <= PRIMARY_ERASED;
      state_r.initialSource <= SOURCE_ERASED;
      state_r.currentSource <= SOURCE_ERASED;
      state_r.newSource <= SOURCE_ERASED;
      state_r.dozeRatio <= DOZE_RESET;
      state_r.postscale <= POSTSCALE_RESET;
      state_r.postShift <= {1'b0, POSTSCALE_RESET};
      state_r.swState <= SW_IDLE;
      state_r.keyHi <= KEY_NONE;
      state_r.keyLo <= KEY_NONE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign currentSource = state_r.currentSource;
  assign requestedSource = state_r.newSource;
  assign primaryMode = state_r.primaryMode;
  assign switchingEnabled = state_r.switchEnOut;
  assign failsafeMonitorEnable = state_r.monitorEnOut;
  assign secondaryOscEnable = state_r.secondaryEnable;
  assign pinMapLock = state_r.pinMapLock;
  assign switchInProgress = state_r.busyOut;
  assign dozeRatioEffective = state_r.dozeRatioEff;
  assign fastRcPostscaleShift = state_r.postShift;
  assign fastRcTrim = state_r.trim;

endmodule : osc_select_ctrl

//--- verification/osc_select_ctrl_monitor.sv
// Checker: port-level properties of the oscillator select block
`timescale 1ns/10ps
module osc_select_ctrl_monitor
  import osc_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] switchMonitorCfg,
  input wire logic [1:0] primaryModeCfg,
  input wire logic [2:0] initialSourceCfg,
  input wire logic [2:0] currentSource,
  input wire logic [1:0] primaryMode,
  input wire logic switchingEnabled,
  input wire logic failsafeMonitorEnable,
  input wire logic switchInProgress,
  input wire logic [3:0] fastRcPostscaleShift
);
  logic [1:0] age_r;
  // Straps are captured on the first edge after reset, so judge them only later
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_apb_one_wait: assert property (s_setup |-> s_answer) else $error("pready not in second access cycle");
  a_pready_once: assert property (pready |=> !pready) else $error("pready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_switch_gate: assert property (age_r == 2'h3 |-> switchingEnabled == !switchMonitorCfg[1])
    else $error("switching enable does not follow config");
  a_monitor_gate: assert property (age_r == 2'h3 |-> failsafeMonitorEnable == (switchMonitorCfg == 2'h0))
    else $error("fail-safe enable does not follow config");
  a_submode_keep: assert property (age_r == 2'h3 |-> primaryMode == primaryModeCfg)
    else $error("primary sub-mode differs from config");
  a_cur_strap: assert property (age_r == 2'h3 && !switchingEnabled |->
    currentSource == initialSourceCfg && !switchInProgress) else $error("source moved with switching off");
  a_cur_on_done: assert property (age_r == 2'h3 && $changed(currentSource) |-> $past(switchInProgress))
    else $error("current source changed outside a switch");
  a_switch_ends: assert property ($rose(switchInProgress) |-> ##[1:400] !switchInProgress)
    else $error("switch never completed");
  a_shift_code: assert property (fastRcPostscaleShift <= 4'h8 && fastRcPostscaleShift != 4'h7)
    else $error("postscale shift out of range");
endmodule : osc_select_ctrl_monitor

//--- verification/osc_select_ctrl_tb_top.sv
// Testbench: registers, doze and postscale codes, switching, locks
`timescale 1ns/10ps
module osc_select_ctrl_tb_top;
  import osc_ctrl_pkg::*;
  typedef struct {logic [11:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic clk_sys = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, re;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [3:0] pstrb = 4'h0, fastRcPostscaleShift, k;
  logic pready, pslverr, pinMapLockOneWayCfg = 1'h0, clockFailDetect = 1'h0, pllLocked = 1'h0;
  logic newSourceReady = 1'h0, newSourceTick = 1'h0, interruptEvent = 1'h0;
  logic [1:0] switchMonitorCfg = 2'h3, primaryModeCfg = 2'h3, primaryMode;
  logic [2:0] initialSourceCfg = 3'h7, currentSource, requestedSource, dozeRatioEffective;
  logic switchingEnabled, failsafeMonitorEnable, secondaryOscEnable, pinMapLock, switchInProgress;
  logic [5:0] fastRcTrim;
  int errors = 0, total_checks = 0, cyc = 0;
  row_t rows [7] = '{
    '{12'h004, 4'h1, 32'hFFFF, 32'h7F40, 1'h0},
    '{12'h004, 4'h2, 32'h0600, 32'h0640, 1'h0},
    '{12'h008, 4'h1, 32'hFFFF, 32'h003F, 1'h0},
    '{12'h008, 4'h1, 32'h0020, 32'h0020, 1'h0},
    '{12'h008, 4'h2, 32'hFF1F, 32'h0020, 1'h0},
    '{12'h000, 4'h3, 32'hFFFF, 32'h7700, 1'h0},
    '{12'h00C, 4'h3, 32'hFFFF, 32'h0000, 1'h1}};

  osc_select_ctrl DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switchMonitorCfg(switchMonitorCfg), .primaryModeCfg(primaryModeCfg), .initialSourceCfg(initialSourceCfg),
    .pinMapLockOneWayCfg(pinMapLockOneWayCfg), .clockFailDetect(clockFailDetect), .pllLocked(pllLocked),
    .newSourceReady(newSourceReady), .newSourceTick(newSourceTick), .interruptEvent(interruptEvent),
    .currentSource(currentSource), .requestedSource(requestedSource), .primaryMode(primaryMode),
    .switchingEnabled(switchingEnabled), .failsafeMonitorEnable(failsafeMonitorEnable),
    .secondaryOscEnable(secondaryOscEnable), .pinMapLock(pinMapLock), .switchInProgress(switchInProgress),
    .dozeRatioEffective(dozeRatioEffective), .fastRcPostscaleShift(fastRcPostscaleShift), .fastRcTrim(fastRcTrim)
  );

  initial forever #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pstrb <= s;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rv = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask : apb

  // Key pair then the guarded byte; any transfer in between would disarm it
  task automatic uw(input logic hi, input logic [31:0] d);
    if (hi) begin
      apb(1'h1, OFS_OSC_CONTROL, 4'h2, {16'h0, KEY_HI_FIRST, 8'h0});
      apb(1'h1, OFS_OSC_CONTROL, 4'h2, {16'h0, KEY_HI_SECOND, 8'h0});
    end else begin
      apb(1'h1, OFS_OSC_CONTROL, 4'h1, {24'h0, KEY_LO_FIRST});
      apb(1'h1, OFS_OSC_CONTROL, 4'h1, {24'h0, KEY_LO_SECOND});
    end
    apb(1'h1, OFS_OSC_CONTROL, hi ? 4'h2 : 4'h1, d);
  endtask : uw

  task automatic rd(input logic [11:0] a);
    apb(1'h0, a, 4'h0, 32'h0);
  endtask : rd

  task automatic rst(input logic [1:0] sm, input logic [1:0] pm, input logic [2:0] is, input logic ow);
    sys_rst <= 1'h1;
    switchMonitorCfg <= sm;
    primaryModeCfg <= pm;
    initialSourceCfg <= is;
    pinMapLockOneWayCfg <= ow;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask : rst

  task automatic pulse(input logic irq);
    if (irq) interruptEvent <= 1'h1;
    else clockFailDetect <= 1'h1;
    @(posedge clk_sys);
    interruptEvent <= 1'h0;
    clockFailDetect <= 1'h0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse

  task automatic tk(input int n);
    repeat (n) begin
      newSourceTick <= 1'h1;
      @(posedge clk_sys);
      newSourceTick <= 1'h0;
      @(posedge clk_sys);
    end
  endtask : tk

  initial begin
    @(posedge clk_sys);
    rst(2'h3, 2'h3, 3'h7, 1'h0);
    chk("swEn", switchingEnabled, 1'h0);
    chk("failsafe", failsafeMonitorEnable, 1'h0);
    rd(OFS_OSC_CONTROL);
    chk("ctl", rv, 32'h7700);
    rd(OFS_CLOCK_DIVIDER);
    chk("div", rv, 32'h3140);
    rd(OFS_FAST_RC_TUNE);
    chk("trimRd", rv, 32'h0);
    uw(1'h0, 32'h1);
    pulse(1'h0);
    rd(OFS_OSC_CONTROL);
    chk("ctlOff", rv, 32'h7700);
    uw(1'h0, 32'h40);
    chk("pinOn", pinMapLock, 1'h1);
    uw(1'h0, 32'h0);
    chk("pinClr", pinMapLock, 1'h0);
    apb(1'h1, OFS_OSC_CONTROL, 4'h1, 32'h42);
    chk("noKey", pinMapLock, 1'h0);
    chk("noKeySec", secondaryOscEnable, 1'h0);
    for (k = 4'h0; k < 4'h8; k++) begin
      apb(1'h1, OFS_CLOCK_DIVIDER, 4'h2, {17'h0, k[2:0], 1'h1, k[2:0], 8'h0});
      chk("eff", dozeRatioEffective, k[2:0]);
      chk("shift", fastRcPostscaleShift, k == 4'h7 ? 4'h8 : k);
      rd(OFS_CLOCK_DIVIDER);
      chk("divK", rv, {17'h0, k[2:0], 1'h1, k[2:0], 8'h40});
    end
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].s, rows[i].d);
      chk("err", re, rows[i].e);
      rd(rows[i].a);
      chk("row", rv, rows[i].x);
    end
    chk("trim", fastRcTrim, 6'h20);
    chk("eff0", dozeRatioEffective, 3'h0);
    apb(1'h1, OFS_CLOCK_DIVIDER, 4'h2, 32'hBB00);
    pulse(1'h1);
    chk("recover", dozeRatioEffective, 3'h0);
    rd(OFS_CLOCK_DIVIDER);
    chk("divRecover", rv, 32'hB340);
    apb(1'h1, OFS_CLOCK_DIVIDER, 4'h2, 32'h3B00);
    pulse(1'h1);
    chk("noRecover", dozeRatioEffective, 3'h3);
    rst(2'h0, 2'h1, 3'h0, 1'h1);
    chk("swEn", switchingEnabled, 1'h1);
    chk("failsafe", failsafeMonitorEnable, 1'h1);
    chk("pmode", primaryMode, 2'h1);
    pulse(1'h0);
    rd(OFS_OSC_CONTROL);
    chk("failFlag", rv, 32'h0008);
    uw(1'h0, 32'h0);
    uw(1'h0, 32'h08);
    rd(OFS_OSC_CONTROL);
    chk("failClr", rv, 32'h0);
    uw(1'h1, 32'h0300);
    rd(OFS_OSC_CONTROL);
    chk("new", rv, 32'h0300);
    chk("reqSrc", requestedSource, 3'h3);
    uw(1'h0, 32'h1);
    repeat (6) @(posedge clk_sys);
    chk("busy", switchInProgress, 1'h1);
    chk("wait", currentSource, 3'h0);
    newSourceReady <= 1'h1;
    pllLocked <= 1'h1;
    // Let the sequencer pass ready and lock before the first counted tick
    repeat (2) @(posedge clk_sys);
    tk(9);
    repeat (4) @(posedge clk_sys);
    chk("nine", currentSource, 3'h0);
    tk(1);
    repeat (4) @(posedge clk_sys);
    chk("ten", currentSource, 3'h3);
    rd(OFS_OSC_CONTROL);
    chk("done", rv, 32'h3320);
    uw(1'h0, 32'h1);
    repeat (4) @(posedge clk_sys);
    rd(OFS_OSC_CONTROL);
    chk("abort", rv & 32'hFFDF, 32'h3300);
    uw(1'h0, 32'h80);
    uw(1'h1, 32'h0);
    rd(OFS_OSC_CONTROL);
    chk("selLock", rv & 32'hFFDF, 32'h3380);
    uw(1'h0, 32'hC2);
    rd(OFS_OSC_CONTROL);
    chk("pinSet", rv & 32'hFFDF, 32'h33C2);
    chk("pinOut", pinMapLock, 1'h1);
    uw(1'h0, 32'h80);
    rd(OFS_OSC_CONTROL);
    chk("oneWay", rv & 32'hFFDF, 32'h33C0);
    chk("secOff", secondaryOscEnable, 1'h0);
    summarize();
  end
endmodule : osc_select_ctrl_tb_top

bind osc_select_ctrl osc_select_ctrl_monitor mon (.clk_sys, .sys_rst, .psel, .penable, .pready, .pslverr,
  .switchMonitorCfg, .primaryModeCfg, .initialSourceCfg, .currentSource, .primaryMode, .switchingEnabled,
  .failsafeMonitorEnable, .switchInProgress, .fastRcPostscaleShift);
